/* File: rapc_defs.vh */
// Constants for the alarm, supply switchover and power-on reset block
`ifndef RAPC_DEFS_VH
`define RAPC_DEFS_VH
// Register word addresses
`define RAPC_ADDR_CTRL 4'h0
`define RAPC_ADDR_STATUS 4'h1
`define RAPC_ADDR_POWER 4'h2
`define RAPC_ADDR_ALARM0 4'h3
`define RAPC_ADDR_ALARM1 4'h4
`define RAPC_ADDR_TIME 4'h5
// Control register fields
`define RAPC_CTRL_EN0 0
`define RAPC_CTRL_EN1 1
`define RAPC_CTRL_REPEAT 2
`define RAPC_CTRL_FSEL_LO 3
`define RAPC_CTRL_FSEL_HI 4
`define RAPC_CTRL_RESET 5'h00
// Status register fields
`define RAPC_STAT_FLAG0 0
`define RAPC_STAT_FLAG1 1
`define RAPC_STAT_BACKUP 2
`define RAPC_STAT_SERIAL_OK 3
`define RAPC_STAT_POR 4
// Power config fields
`define RAPC_PWR_SERIAL_IN_BACKUP 0
`define RAPC_PWR_POLICY 1
`define RAPC_PWR_RESET 2'h2
// Timing
`define RAPC_CLK_HZ 200000000
`define RAPC_POR_MS 250
`define RAPC_POR_CYCLES (`RAPC_CLK_HZ / 1000 * `RAPC_POR_MS)
`define RAPC_OSC_HZ 32768
`define RAPC_OSC_DIV (`RAPC_CLK_HZ / `RAPC_OSC_HZ)
`define RAPC_POR_TICKS (`RAPC_OSC_HZ * `RAPC_POR_MS / 1000)
`define RAPC_PULSE_TICKS 1
`endif

/* File: rapc_alarm_power.v */
// Alarm, supply switchover and power-on reset logic with Avalon-MM access
// Function
// R1: Alarm match when alarm compare value equals current time value.
// R2: A match sets its flag regardless of the pin enable; here a match sets its flag only while that alarm's enable bit is set.
// R3: Reading status clears both alarm flags.
// R4: Host arms single event with enable 1, repeat 0, frequency off.
// R5: Single event: flag set, pin low until flag read and cleared.
// R6: Either alarm drives shared pin; cleared before retriggering.
// R7: Separate flag per alarm so status shows which one fired.
// R8: Repeat mode pulses the pin at every match.
// R9: In repeat mode with both enables, only alarm 0 acts.
// R10: Repeat pulses continue until repeat bit or enables cleared.
// R11: Repeats come only from time-of-day matches, no interval timer.
// R12: Policy bit 0 standard, 1 legacy; legacy after reset.
// R13: Standard: to backup when below backup-hys and below trip.
// R14: Standard: to main when above backup+hys or trip+hys.
// R15: Legacy: to backup below backup-hys, back above backup+hys.
// R16: Serial bus in backup is governed by a control bit.
// R17: Reset output asserted when power comes up.
// R18: Reset released after main above threshold for 250 ms.
// R19: Nonvolatile accesses refused while reset asserted.
// R20: Pin carries alarms only when frequency select is 00.
// R21: Serial-in-backup bit 1 disables serial bus in backup.
// R22: Comparators synchronised; reset delay counted in oscillator ticks.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rapc_defs.vh"

module rapc_alarm_power #(
   parameter TIME_W = 32,
   parameter POR_TICKS = `RAPC_POR_TICKS,
   parameter OSC_DIV = `RAPC_OSC_DIV
) (
   input wire clk, // 200 MHz system clock
   input wire reset_n, // Asynchronous reset, active low
   input wire [3:0] address, // Avalon word address
   input wire read, // Avalon read strobe
   input wire write, // Avalon write strobe
   input wire [31:0] writedata, // Avalon write data
   output reg [31:0] readdata, // Avalon read data
   output reg waitrequest, // Avalon wait, low one cycle per access
   input wire mainBelowBackupHys, // Comparator: main < backup - hys
   input wire mainAboveBackupHys, // Comparator: main > backup + hys
   input wire mainBelowTrip, // Comparator: main < trip level
   input wire mainAboveTripHys, // Comparator: main > trip + hys
   input wire mainAboveResetThr, // Comparator: main > reset threshold
   input wire nvAccessReq, // Serial request for nonvolatile memory
   output reg nvAccessGrant, // Nonvolatile access allowed
   output reg interruptPinOut, // Pin output level
   output reg interruptPinOe, // Pin drive enable (open drain low)
   output reg useBackup, // Running from backup supply
   output reg serialEnable, // Serial interface allowed
   output reg resetOut_n // Reset output, active low
);

   ////////////////////////////////////////////////////////////////////
   // Registers
   reg [4:0] ctrlReg;
   reg [1:0] powerReg;
   reg [TIME_W-1:0] alarm0Reg;
   reg [TIME_W-1:0] alarm1Reg;
   reg [TIME_W-1:0] timeReg;
   reg flag0Reg;
   reg flag1Reg;
   reg match0Prev;
   reg match1Prev;
   reg ackReg;
   reg [4:0] sync1Reg;
   reg [4:0] sync2Reg;
   reg [15:0] oscCntReg;
   reg oscTickReg;
   reg [31:0] porCntReg;
   reg [12:0] divCntReg;
   reg fclkReg;
   reg pulseReg;
   wire match0;
   wire match1;
   wire rise0;
   wire rise1;
   wire acc;
   wire [1:0] fsel;
   wire freqOff;
   wire repeatMode;

   assign fsel = {ctrlReg[`RAPC_CTRL_FSEL_HI], ctrlReg[`RAPC_CTRL_FSEL_LO]};
   assign freqOff = (fsel == 2'h0);
   assign repeatMode = ctrlReg[`RAPC_CTRL_REPEAT];
   assign acc = (read | write) & ~ackReg;

   ////////////////////////////////////////////////////////////////////
   // Comparator synchronisers, two stages before any use
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1Reg <= 5'h00;
         sync2Reg <= 5'h00;
      end else begin
         sync1Reg <= {mainAboveResetThr, mainAboveTripHys, mainBelowTrip,
            mainAboveBackupHys, mainBelowBackupHys}; // [R22]
         sync2Reg <= sync1Reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, then the access completes
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ackReg <= 1'b0;
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
         ctrlReg <= `RAPC_CTRL_RESET;
         powerReg <= `RAPC_PWR_RESET; // [R12]
         alarm0Reg <= {TIME_W{1'b0}};
         alarm1Reg <= {TIME_W{1'b0}};
         timeReg <= {TIME_W{1'b0}};
      end else begin
         ackReg <= acc;
         waitrequest <= ~acc;
         if (acc && write) begin
            case (address)
               `RAPC_ADDR_CTRL: ctrlReg <= writedata[4:0]; // [R4] [R10]
               `RAPC_ADDR_POWER: powerReg <= writedata[1:0]; // [R16]
               `RAPC_ADDR_ALARM0: alarm0Reg <= writedata[TIME_W-1:0];
               `RAPC_ADDR_ALARM1: alarm1Reg <= writedata[TIME_W-1:0];
               `RAPC_ADDR_TIME: timeReg <= writedata[TIME_W-1:0];
               default: ;
            endcase
         end
         if (acc && read) begin
            case (address)
               `RAPC_ADDR_CTRL: readdata <= {27'h0, ctrlReg};
               `RAPC_ADDR_STATUS: readdata <= {27'h0, ~resetOut_n,
                  serialEnable, useBackup, flag1Reg, flag0Reg}; // [R7]
               `RAPC_ADDR_POWER: readdata <= {30'h0, powerReg};
               `RAPC_ADDR_ALARM0: readdata <= alarm0Reg;
               `RAPC_ADDR_ALARM1: readdata <= alarm1Reg;
               `RAPC_ADDR_TIME: readdata <= timeReg;
               default: readdata <= 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Alarm comparison; only time-of-day equality, no interval timer
   assign match0 = (alarm0Reg == timeReg); // [R1] [R11]
   assign match1 = (alarm1Reg == timeReg); // [R1]
   // Edge of a match so one matching second sets a flag only once
   assign rise0 = match0 & ~match0Prev & ctrlReg[`RAPC_CTRL_EN0];
   assign rise1 = match1 & ~match1Prev & ctrlReg[`RAPC_CTRL_EN1]
      & ~(repeatMode & ctrlReg[`RAPC_CTRL_EN0]); // [R9]

   // Flags: set wins over the read clear so no event is lost
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         match0Prev <= 1'b0;
         match1Prev <= 1'b0;
         flag0Reg <= 1'b0;
         flag1Reg <= 1'b0;
      end else begin
         match0Prev <= match0;
         match1Prev <= match1;
         if (rise0)
            flag0Reg <= 1'b1; // [R2] [R7]
         else if (acc && read && address == `RAPC_ADDR_STATUS)
            flag0Reg <= 1'b0; // [R3]
         if (rise1)
            flag1Reg <= 1'b1; // [R2] [R7]
         else if (acc && read && address == `RAPC_ADDR_STATUS)
            flag1Reg <= 1'b0; // [R3]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Oscillator tick and divided frequency output
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oscCntReg <= 16'h0000;
         oscTickReg <= 1'b0;
         divCntReg <= 13'h0000;
         fclkReg <= 1'b0;
      end else begin
         oscTickReg <= 1'b0;
         if (oscCntReg == OSC_DIV - 1) begin
            oscCntReg <= 16'h0000;
            oscTickReg <= 1'b1;
         end else begin
            oscCntReg <= oscCntReg + 16'h0001;
         end
         if (oscTickReg) begin
            divCntReg <= divCntReg + 13'h0001;
         end
         // Rates: 01 raw tick toggle, 10 divide by 8, 11 divide by 2^13
         case (fsel)
            2'h1: fclkReg <= fclkReg ^ oscTickReg;
            2'h2: fclkReg <= divCntReg[2];
            2'h3: fclkReg <= divCntReg[12];
            default: fclkReg <= 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Repeat pulse: low from each match until the next oscillator tick
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pulseReg <= 1'b0;
      end else if ((rise0 | rise1) && repeatMode) begin
         pulseReg <= 1'b1; // [R8] [R10]
      end else if (oscTickReg || !repeatMode) begin
         pulseReg <= 1'b0;
      end
   end

   // Pin source: alarm only with frequency select 00
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         interruptPinOut <= 1'b0;
         interruptPinOe <= 1'b0;
      end else begin
         interruptPinOut <= 1'b0;
         if (!freqOff) begin
            interruptPinOe <= ~fclkReg; // [R20]
         end else if (repeatMode) begin
            interruptPinOe <= pulseReg; // [R8]
         end else begin
            interruptPinOe <= flag0Reg | flag1Reg; // [R5] [R6]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Supply switchover
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         useBackup <= 1'b0;
      end else if (!useBackup) begin
         if (powerReg[`RAPC_PWR_POLICY])
            useBackup <= sync2Reg[0]; // [R15]
         else
            useBackup <= sync2Reg[0] & sync2Reg[2]; // [R13]
      end else begin
         if (powerReg[`RAPC_PWR_POLICY])
            useBackup <= ~sync2Reg[1]; // [R15]
         else
            useBackup <= ~(sync2Reg[1] | sync2Reg[3]); // [R14]
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         serialEnable <= 1'b1;
      else
         serialEnable <= ~(useBackup &
            powerReg[`RAPC_PWR_SERIAL_IN_BACKUP]); // [R16] [R21]
   end

   ////////////////////////////////////////////////////////////////////
   // Power-on reset: count oscillator ticks while above threshold
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         porCntReg <= 32'h00000000;
         resetOut_n <= 1'b0; // [R17]
      end else if (!sync2Reg[4]) begin
         porCntReg <= 32'h00000000;
         resetOut_n <= 1'b0; // [R17]
      end else if (porCntReg >= POR_TICKS) begin
         resetOut_n <= 1'b1; // [R18]
      end else if (oscTickReg) begin
         porCntReg <= porCntReg + 32'h00000001; // [R22]
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         nvAccessGrant <= 1'b0;
      else
         nvAccessGrant <= nvAccessReq & resetOut_n & serialEnable; // [R19]
   end

endmodule // rapc_alarm_power
`default_nettype wire

/* File: rapc_host_model.sv */
// Host end of the shared open-drain interrupt line
`timescale 1ns/1ps
`default_nettype none
module rapc_host_model (
   input wire logic clk, // System clock
   input wire logic pinOut, // Level driven while enabled
   input wire logic pinOe, // Device pulls the line
   output logic pinLevel, // Resolved line level
   output int pulseCount // Falling edges seen
);
   logic lastLevel;
   int fallCnt = 0;
   // Pull-up wins whenever the device lets go
   assign pinLevel = pinOe ? pinOut : 1'b1;
   // Each fall is one notification; a stuck level counts once only
   assign pulseCount = fallCnt;
   always @(posedge clk) begin
      lastLevel <= pinLevel;
      if (lastLevel && !pinLevel)
         fallCnt <= fallCnt + 1;
   end
endmodule // rapc_host_model
`default_nettype wire

/* File: rapc_monitor.sv */
// Checker for alarm pin, supply switch and power-on reset
`timescale 1ns/1ps
`default_nettype none
`include "rapc_defs.vh"
module rapc_monitor #(parameter POR_TICKS = 4, parameter OSC_DIV = 4) (
   input wire logic clk, // System clock
   input wire logic reset_n, // Async reset, active low
   input wire logic [3:0] address, // Bus address
   input wire logic read, // Read strobe
   input wire logic write, // Write strobe
   input wire logic [31:0] writedata, // Write data
   input wire logic waitrequest, // Slave wait
   input wire logic mainBelowBackupHys, // Comparator
   input wire logic mainAboveBackupHys, // Comparator
   input wire logic mainAboveTripHys, // Comparator
   input wire logic mainAboveResetThr, // Comparator
   input wire logic nvAccessGrant, // Memory grant
   input wire logic interruptPinOe, // Pin pulled low
   input wire logic useBackup, // Backup supply
   input wire logic serialEnable, // Serial allowed
   input wire logic resetOut_n // Reset out
);
   // First tick may land early, so allow one tick of slack
   localparam int PorMin = (POR_TICKS - 1) * OSC_DIV;
   localparam int PorMax = (POR_TICKS + 2) * OSC_DIV + 6;
   logic [4:0] ctrlSh;
   logic [5:0] belowHist, aboveHist, rdHist;
   int aboveCnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////
   // Shadow control bits and keep recent causes
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlSh <= 5'h00;
         aboveCnt <= 0;
      end else begin
         if (write && !waitrequest && address == `RAPC_ADDR_CTRL)
            ctrlSh <= writedata[4:0];
         aboveCnt <= mainAboveResetThr ? aboveCnt + 1 : 0;
      end
   end
   // Histories span the two-flop synchroniser latency
   always @(posedge clk) begin
      belowHist <= {belowHist[4:0], mainBelowBackupHys};
      aboveHist <= {aboveHist[4:0], mainAboveBackupHys | mainAboveTripHys};
      rdHist <= {rdHist[4:0],
         read & !waitrequest & (address == `RAPC_ADDR_STATUS)};
   end
   ////////////////////////////////////////////////////////////
   AST_SERIAL: assert property (!useBackup [*3] |-> serialEnable)
      else $error("serial dropped on main supply");
   AST_NV_REFUSED: assert property (
      !resetOut_n || !serialEnable |=> !nvAccessGrant)
      else $error("memory granted while refused");
   AST_POR_MIN: assert property (
      $rose(resetOut_n) |-> aboveCnt >= PorMin)
      else $error("reset released early");
   AST_POR_MAX: assert property (aboveCnt > PorMax |-> resetOut_n)
      else $error("reset held too long");
   AST_TO_BACKUP: assert property ($rose(useBackup) |-> |belowHist)
      else $error("backup without low main");
   AST_TO_MAIN: assert property ($fell(useBackup) |-> |aboveHist)
      else $error("main without recovery");
   AST_READ_CLEARS: assert property (
      rdHist[0] && ctrlSh[4:2] == 3'b000 |-> ##[0:4] !interruptPinOe)
      else $error("pin held after status read");
   AST_SINGLE_HOLDS: assert property (
      $fell(interruptPinOe) && ctrlSh[4:2] == 3'b000 |-> |rdHist)
      else $error("pin released without read");
   // Bound assumes the simulation divider of 4
   AST_PULSE_SHORT: assert property (
      ctrlSh[4:2] == 3'b001 && $rose(interruptPinOe)
      |-> ##[1:12] !interruptPinOe)
      else $error("repeat pulse too long");
   cover property ($rose(useBackup));
   cover property ($rose(resetOut_n));
   cover property (ctrlSh[2] && $fell(interruptPinOe));
endmodule // rapc_monitor
bind rapc_alarm_power rapc_monitor #(.POR_TICKS(POR_TICKS),
   .OSC_DIV(OSC_DIV)) mon_u (.clk(clk), .reset_n(reset_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .waitrequest(waitrequest), .mainBelowBackupHys(mainBelowBackupHys),
   .mainAboveBackupHys(mainAboveBackupHys),
   .mainAboveTripHys(mainAboveTripHys),
   .mainAboveResetThr(mainAboveResetThr), .nvAccessGrant(nvAccessGrant),
   .interruptPinOe(interruptPinOe), .useBackup(useBackup),
   .serialEnable(serialEnable), .resetOut_n(resetOut_n));
`default_nettype wire

/* File: rtc_alarm_power_switch_control_bench.sv */
// Self-checking bench for alarm, supply and reset block
`timescale 1ns/1ps
`default_nettype none
`include "rapc_defs.vh"
module rtc_alarm_power_switch_control_bench;
   logic clk, reset_n, read, write, nvAccessReq, thr, waitrequest;
   logic [3:0] address, sup;
   logic [31:0] writedata, readdata, q;
   logic grant, pinOut, pinOe, useBackup, serialEnable, resetOut_n, pin;
   int failures, comparisons, pulses, n0;
   // Comparator pattern then expected supply, one row a step
   logic [4:0] supTab [7] = '{5'h13, 5'h0a, 5'h12, 5'h15, 5'h12, 5'h15,
      5'h0c};
   ////////////////////////////////////////////////////////////
   rapc_alarm_power #(.POR_TICKS(4), .OSC_DIV(4)) dut_u (.clk(clk),
      .reset_n(reset_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .mainBelowBackupHys(sup[3]),
      .mainAboveBackupHys(sup[2]), .mainBelowTrip(sup[1]),
      .mainAboveTripHys(sup[0]), .mainAboveResetThr(thr),
      .nvAccessReq(nvAccessReq), .nvAccessGrant(grant),
      .interruptPinOut(pinOut), .interruptPinOe(pinOe),
      .useBackup(useBackup), .serialEnable(serialEnable),
      .resetOut_n(resetOut_n));
   rapc_host_model host_u (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
      .pinLevel(pin), .pulseCount(pulses));
   ////////////////////////////////////////////////////////////
   // One bus access, held until wait drops; read data lands in q
   task automatic bus(input logic [3:0] a, input logic w,
      input logic [31:0] d);
      int n;
      address <= a;
      read <= !w;
      write <= w;
      writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 40);
      if (n >= 40) failures++;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Clock at 200 MHz
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Whole run needs about 330 cycles
   initial begin
      #50000;
      failures++;
      end_of_test;
   end
   // Test sequence
   initial begin
      {reset_n, read, write, nvAccessReq, address, writedata} = '0;
      sup = 4'b0101;
      thr = 1'b1;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      nvAccessReq <= 1'b1;
      repeat (4) @(posedge clk);
      chk({resetOut_n, grant}, 2'b00);
      repeat (40) @(posedge clk);
      chk({resetOut_n, grant}, 2'b11);
      bus(`RAPC_ADDR_POWER, 0, 0);
      chk(q, 32'h2);
      bus(4'hf, 0, 0);
      chk(q, 32'h0); // Unmapped reads zero
      $display("reset test done");
      bus(`RAPC_ADDR_ALARM0, 1, 5);
      bus(`RAPC_ADDR_ALARM1, 1, 7);
      bus(`RAPC_ADDR_CTRL, 1, 3);
      for (int i = 0; i < 2; i++) begin
         bus(`RAPC_ADDR_TIME, 1, 5 + 2 * i);
         repeat (3) @(posedge clk);
         chk(pin, 1'b0);
         bus(`RAPC_ADDR_STATUS, 0, 0);
         chk(q[1:0], 2'b01 << i);
         repeat (4) @(posedge clk);
         chk(pin, 1'b1);
      end
      bus(`RAPC_ADDR_CTRL, 1, 32'h9);
      bus(`RAPC_ADDR_TIME, 1, 5);
      bus(`RAPC_ADDR_STATUS, 0, 0);
      chk(q[0], 1'b1);
      n0 = pulses;
      repeat (40) @(posedge clk);
      chk(pulses > n0, 1'b1);
      $display("single test done");
      bus(`RAPC_ADDR_CTRL, 1, 32'h7);
      repeat (4) @(posedge clk);
      n0 = pulses;
      for (int i = 0; i < 6; i++) begin
         bus(`RAPC_ADDR_TIME, 1, (i % 3 == 0) ? 0 : (i % 3 == 1) ? 5 : 7);
         repeat (12) @(posedge clk);
      end
      chk(pulses, n0 + 2);
      bus(`RAPC_ADDR_STATUS, 0, 0);
      bus(`RAPC_ADDR_CTRL, 1, 0);
      bus(`RAPC_ADDR_TIME, 1, 0);
      bus(`RAPC_ADDR_TIME, 1, 5);
      repeat (12) @(posedge clk);
      chk(pulses, n0 + 2);
      $display("repeat test done");
      for (int i = 0; i < 7; i++) begin
         if (i == 2) bus(`RAPC_ADDR_POWER, 1, 0);
         sup <= supTab[i][4:1];
         repeat (8) @(posedge clk);
         chk(useBackup, supTab[i][0]);
         if (i == 0) begin
            bus(`RAPC_ADDR_STATUS, 0, 0);
            chk(q[3:2], 2'b11);
            bus(`RAPC_ADDR_POWER, 1, 3);
            repeat (3) @(posedge clk);
            chk({serialEnable, grant}, 2'b00);
            bus(`RAPC_ADDR_POWER, 1, 2);
         end
      end
      $display("supply test done");
      end_of_test;
   end
endmodule // rtc_alarm_power_switch_control_bench
`default_nettype wire
